// File: shared/dtm_pkg.sv
// package: register map, field positions and reset values of the dual timer
package dtm_pkg;
	localparam logic [7:0] DTM_OFS_B_LOW = 8'hAC;
	localparam logic [7:0] DTM_OFS_B_HIGH = 8'hAD;
	localparam logic [7:0] DTM_OFS_A_LOW = 8'hAE;
	localparam logic [7:0] DTM_OFS_A_HIGH = 8'hAF;
	localparam logic [7:0] DTM_OFS_CTRL = 8'hCF;
	localparam logic [7:0] DTM_OFS_IRQ_STAT = 8'hD0;
	localparam logic [7:0] DTM_OFS_IRQ_MASK = 8'hD1;
	localparam int DTM_BIT_B_FLAG = 7;
	localparam int DTM_BIT_B_RELOAD = 6;
	localparam int DTM_BIT_B_RUN = 5;
	localparam int DTM_BIT_B_IEN = 4;
	localparam int DTM_BIT_A_FLAG = 3;
	localparam int DTM_BIT_A_RELOAD = 2;
	localparam int DTM_BIT_A_RUN = 1;
	localparam int DTM_BIT_A_IEN = 0;
	localparam logic [7:0] DTM_CTRL_RESET = 8'h00;
	localparam logic [15:0] DTM_COUNT_RESET = 16'h0000;
	localparam logic [1:0] DTM_IRQ_RESET = 2'h0;
	localparam int DTM_WIDTH = 16;
endpackage : dtm_pkg

// File: shared/dtm_tmr_if.sv
// interface: control and status between the register block and one timer
`timescale 1ns/1ns
interface dtm_tmr_if #(parameter int W = 16);
	logic run;
	logic reload_mode;
	logic wr_low;
	logic wr_high;
	logic [7:0] wdata;
	logic [W-1:0] count;
	logic ovf;
	modport ctl (output run, reload_mode, wr_low, wr_high, wdata,
		input count, ovf);
	modport tmr (input run, reload_mode, wr_low, wr_high, wdata,
		output count, ovf);
endinterface : dtm_tmr_if

// File: src/dtm_counter.sv
// one 16-bit timer with free-run and auto-reload modes
`timescale 1ns/1ns
module dtm_counter
	import dtm_pkg::*;
#(
	parameter int W = DTM_WIDTH
)(
	input wire logic i_clk, // system clock
	input wire logic i_rst_n, // synchronised reset
	dtm_tmr_if.tmr bus // control and status
);
	typedef struct packed {
		logic [W-1:0] count;
		logic [W-1:0] reload;
		logic ovf;
	} dtm_cnt_type;
	dtm_cnt_type st;
	dtm_cnt_type next_st;
	logic wrap;
	assign wrap = bus.run && (st.count == {W{1'b1}});
	always_comb
	begin
		next_st = st;
		next_st.ovf = wrap;
		if (bus.run)
		begin
			if (wrap)
				next_st.count = bus.reload_mode ? st.reload : '0;
			else
				next_st.count = st.count + 1'b1;
		end
		if (bus.reload_mode)
		begin
			if (bus.wr_low)
				next_st.reload[7:0] = bus.wdata;
			if (bus.wr_high)
				next_st.reload[15:8] = bus.wdata;
		end
		else
		begin
			if (bus.wr_low)
				next_st.count[7:0] = bus.wdata;
			if (bus.wr_high)
				next_st.count[15:8] = bus.wdata;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st <= '0;
		else
			st <= next_st;
	end
	assign bus.count = st.count;
	assign bus.ovf = st.ovf;

	property p_wrap_free;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wrap && !bus.reload_mode && !bus.wr_low && !bus.wr_high)
			|=> (st.count == '0) && st.ovf;
	endproperty
	a_wrap_free: assert property (p_wrap_free)
		else $error("free-run wrap did not reach zero");
	property p_wrap_reload;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wrap && bus.reload_mode) |=> st.count == $past(st.reload);
	endproperty
	a_wrap_reload: assert property (p_wrap_reload)
		else $error("reload value not loaded on overflow");
	property p_halt;
		@(posedge i_clk) disable iff (!i_rst_n)
		(!bus.run && !bus.wr_low && !bus.wr_high) |=> $stable(st.count);
	endproperty
	a_halt: assert property (p_halt)
		else $error("counter moved while stopped");
	property p_reload_write;
		@(posedge i_clk) disable iff (!i_rst_n)
		(bus.reload_mode && bus.wr_low) |=> st.reload[7:0] == $past(bus.wdata);
	endproperty
	a_reload_write: assert property (p_reload_write)
		else $error("reload byte not stored");
	property p_free_write;
		@(posedge i_clk) disable iff (!i_rst_n)
		(!bus.reload_mode && bus.wr_high) |=> st.count[15:8] == $past(bus.wdata);
	endproperty
	a_free_write: assert property (p_free_write)
		else $error("count byte not written");
	c_wrap_reload: cover property (@(posedge i_clk) wrap && bus.reload_mode);
	c_wrap_free: cover property (@(posedge i_clk) wrap && !bus.reload_mode);
endmodule : dtm_counter

// File: src/dtm_top.sv
// dual 16-bit reload timer: register file, flags and interrupts
`timescale 1ns/1ns
module dtm_top
	import dtm_pkg::*;
(
	input wire logic i_clk, // 20 MHz system clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic [7:0] i_addr, // register address
	input wire logic [7:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [7:0] o_rdata, // read data, cycle after strobe
	output logic o_a_irq, // timer three request
	output logic o_b_irq, // timer four request
	output logic o_irq // summary interrupt
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [1:0] stat;
		logic [1:0] mask;
		logic [7:0] rdata;
	} dtm_top_type;
	dtm_top_type st;
	dtm_top_type next_st;
	logic [1:0] rst_sync;
	logic rst_n;
	logic ctrl_wr;
	logic stat_wr;
	logic mask_wr;
	dtm_tmr_if #(.W(DTM_WIDTH)) a_if ();
	dtm_tmr_if #(.W(DTM_WIDTH)) b_if ();

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// register write strobes
	assign ctrl_wr = i_wr && hit(i_addr, DTM_OFS_CTRL);
	assign stat_wr = i_wr && hit(i_addr, DTM_OFS_IRQ_STAT);
	assign mask_wr = i_wr && hit(i_addr, DTM_OFS_IRQ_MASK);

	// per-timer strobes and controls
	assign a_if.run = st.ctrl[DTM_BIT_A_RUN];
	assign a_if.reload_mode = st.ctrl[DTM_BIT_A_RELOAD];
	assign a_if.wr_low = i_wr && hit(i_addr, DTM_OFS_A_LOW);
	assign a_if.wr_high = i_wr && hit(i_addr, DTM_OFS_A_HIGH);
	assign a_if.wdata = i_wdata;
	assign b_if.run = st.ctrl[DTM_BIT_B_RUN];
	assign b_if.reload_mode = st.ctrl[DTM_BIT_B_RELOAD];
	assign b_if.wr_low = i_wr && hit(i_addr, DTM_OFS_B_LOW);
	assign b_if.wr_high = i_wr && hit(i_addr, DTM_OFS_B_HIGH);
	assign b_if.wdata = i_wdata;

	dtm_counter #(.W(DTM_WIDTH)) u_a (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.bus(a_if)
	);
	dtm_counter #(.W(DTM_WIDTH)) u_b (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.bus(b_if)
	);

	always_comb
	begin
		next_st = st;
		next_st.rdata = 8'h00;
		if (ctrl_wr)
			next_st.ctrl = i_wdata;
		if (stat_wr)
			next_st.stat = st.stat & ~i_wdata[1:0];
		if (mask_wr)
			next_st.mask = i_wdata[1:0];
		// set wins over a same-cycle clear
		if (a_if.ovf)
		begin
			next_st.ctrl[DTM_BIT_A_FLAG] = 1'b1;
			next_st.stat[0] = 1'b1;
		end
		if (b_if.ovf)
		begin
			next_st.ctrl[DTM_BIT_B_FLAG] = 1'b1;
			next_st.stat[1] = 1'b1;
		end
		if (i_rd)
		begin
			unique case (i_addr)
				DTM_OFS_A_LOW: next_st.rdata = a_if.count[7:0];
				DTM_OFS_A_HIGH: next_st.rdata = a_if.count[15:8];
				DTM_OFS_B_LOW: next_st.rdata = b_if.count[7:0];
				DTM_OFS_B_HIGH: next_st.rdata = b_if.count[15:8];
				DTM_OFS_CTRL: next_st.rdata = st.ctrl;
				DTM_OFS_IRQ_STAT: next_st.rdata = {6'h00, st.stat};
				DTM_OFS_IRQ_MASK: next_st.rdata = {6'h00, st.mask};
				default: next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '{ctrl: DTM_CTRL_RESET, stat: DTM_IRQ_RESET,
				mask: DTM_IRQ_RESET, rdata: 8'h00};
		else
			st <= next_st;
	end

	assign o_rdata = st.rdata;
	assign o_a_irq = st.ctrl[DTM_BIT_A_FLAG] && st.ctrl[DTM_BIT_A_IEN];
	assign o_b_irq = st.ctrl[DTM_BIT_B_FLAG] && st.ctrl[DTM_BIT_B_IEN];
	assign o_irq = |(st.stat & st.mask);

	property p_b_flag;
		@(posedge i_clk) disable iff (!rst_n)
		b_if.ovf |=> st.ctrl[DTM_BIT_B_FLAG];
	endproperty
	a_b_flag: assert property (p_b_flag)
		else $error("timer four flag not set");
	property p_a_flag_sticky;
		@(posedge i_clk) disable iff (!rst_n)
		(st.ctrl[DTM_BIT_A_FLAG] && !(i_wr && hit(i_addr, DTM_OFS_CTRL)))
			|=> st.ctrl[DTM_BIT_A_FLAG];
	endproperty
	a_a_flag_sticky: assert property (p_a_flag_sticky)
		else $error("timer three flag dropped by hardware");
	property p_a_irq;
		@(posedge i_clk) disable iff (!rst_n)
		(a_if.ovf && st.ctrl[DTM_BIT_A_IEN] && !ctrl_wr)
			|=> o_a_irq;
	endproperty
	a_a_irq: assert property (p_a_irq)
		else $error("timer three request wrong");
	property p_read_live;
		@(posedge i_clk) disable iff (!rst_n)
		(i_rd && i_addr == DTM_OFS_A_HIGH) |=> o_rdata == $past(a_if.count[15:8]);
	endproperty
	a_read_live: assert property (p_read_live)
		else $error("read did not return live count");
	property p_ctrl_after_reset;
		@(posedge i_clk) $rose(rst_n) |-> st.ctrl == DTM_CTRL_RESET;
	endproperty
	a_ctrl_after_reset: assert property (p_ctrl_after_reset)
		else $error("control not clear after reset");

	// flags: set only by overflow or software, kept until written
	property p_a_flag;
		@(posedge i_clk) disable iff (!rst_n)
		a_if.ovf |=> st.ctrl[DTM_BIT_A_FLAG];
	endproperty
	a_a_flag: assert property (p_a_flag)
		else $error("timer three flag not set");
	property p_b_flag_sticky;
		@(posedge i_clk) disable iff (!rst_n)
		(st.ctrl[DTM_BIT_B_FLAG] && !ctrl_wr)
			|=> st.ctrl[DTM_BIT_B_FLAG];
	endproperty
	a_b_flag_sticky: assert property (p_b_flag_sticky)
		else $error("timer four flag dropped by hardware");
	property p_a_flag_quiet;
		@(posedge i_clk) disable iff (!rst_n)
		(!st.ctrl[DTM_BIT_A_FLAG] && !a_if.ovf && !ctrl_wr)
			|=> !st.ctrl[DTM_BIT_A_FLAG];
	endproperty
	a_a_flag_quiet: assert property (p_a_flag_quiet)
		else $error("timer three flag set without overflow");
	property p_b_flag_quiet;
		@(posedge i_clk) disable iff (!rst_n)
		(!st.ctrl[DTM_BIT_B_FLAG] && !b_if.ovf && !ctrl_wr)
			|=> !st.ctrl[DTM_BIT_B_FLAG];
	endproperty
	a_b_flag_quiet: assert property (p_b_flag_quiet)
		else $error("timer four flag set without overflow");

	// requests follow flag and enable
	property p_b_irq;
		@(posedge i_clk) disable iff (!rst_n)
		(b_if.ovf && st.ctrl[DTM_BIT_B_IEN] && !ctrl_wr)
			|=> o_b_irq;
	endproperty
	a_b_irq: assert property (p_b_irq)
		else $error("timer four request not raised");
	property p_a_irq_gate;
		@(posedge i_clk) disable iff (!rst_n)
		!st.ctrl[DTM_BIT_A_IEN] |-> !o_a_irq;
	endproperty
	a_a_irq_gate: assert property (p_a_irq_gate)
		else $error("timer three request while disabled");
	property p_b_irq_gate;
		@(posedge i_clk) disable iff (!rst_n)
		!st.ctrl[DTM_BIT_B_IEN] |-> !o_b_irq;
	endproperty
	a_b_irq_gate: assert property (p_b_irq_gate)
		else $error("timer four request while disabled");

	// control register writes and hold
	property p_ctrl_write;
		@(posedge i_clk) disable iff (!rst_n)
		(ctrl_wr && !a_if.ovf && !b_if.ovf)
			|=> st.ctrl == $past(i_wdata);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control write not stored");
	property p_ctrl_hold;
		@(posedge i_clk) disable iff (!rst_n)
		(!ctrl_wr && !a_if.ovf && !b_if.ovf)
			|=> $stable(st.ctrl);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold)
		else $error("control changed without write");

	// read path
	property p_read_a_low;
		@(posedge i_clk) disable iff (!rst_n)
		(i_rd && i_addr == DTM_OFS_A_LOW) |=>
			o_rdata == $past(a_if.count[7:0]);
	endproperty
	a_read_a_low: assert property (p_read_a_low)
		else $error("timer three low byte read wrong");
	property p_read_b_low;
		@(posedge i_clk) disable iff (!rst_n)
		(i_rd && i_addr == DTM_OFS_B_LOW) |=>
			o_rdata == $past(b_if.count[7:0]);
	endproperty
	a_read_b_low: assert property (p_read_b_low)
		else $error("timer four low byte read wrong");
	property p_read_b_high;
		@(posedge i_clk) disable iff (!rst_n)
		(i_rd && i_addr == DTM_OFS_B_HIGH) |=>
			o_rdata == $past(b_if.count[15:8]);
	endproperty
	a_read_b_high: assert property (p_read_b_high)
		else $error("timer four high byte read wrong");
	property p_read_ctrl;
		@(posedge i_clk) disable iff (!rst_n)
		(i_rd && i_addr == DTM_OFS_CTRL) |=>
			o_rdata == $past(st.ctrl);
	endproperty
	a_read_ctrl: assert property (p_read_ctrl)
		else $error("control read wrong");
	property p_rdata_idle;
		@(posedge i_clk) disable iff (!rst_n)
		!i_rd |=> o_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside read cycle");

	// overflow only from a running all-ones count
	property p_a_ovf_src;
		@(posedge i_clk) disable iff (!rst_n)
		a_if.ovf |->
			$past(a_if.run) && ($past(a_if.count) == '1);
	endproperty
	a_a_ovf_src: assert property (p_a_ovf_src)
		else $error("timer three overflow without wrap");
	property p_b_ovf_src;
		@(posedge i_clk) disable iff (!rst_n)
		b_if.ovf |->
			$past(b_if.run) && ($past(b_if.count) == '1);
	endproperty
	a_b_ovf_src: assert property (p_b_ovf_src)
		else $error("timer four overflow without wrap");

	// interrupt status and summary output
	property p_a_stat;
		@(posedge i_clk) disable iff (!rst_n)
		a_if.ovf |=> st.stat[0];
	endproperty
	a_a_stat: assert property (p_a_stat)
		else $error("timer three status not set");
	property p_b_stat;
		@(posedge i_clk) disable iff (!rst_n)
		b_if.ovf |=> st.stat[1];
	endproperty
	a_b_stat: assert property (p_b_stat)
		else $error("timer four status not set");
	property p_stat_clear;
		@(posedge i_clk) disable iff (!rst_n)
		(stat_wr && i_wdata[0] && !a_if.ovf) |=>
			!st.stat[0];
	endproperty
	a_stat_clear: assert property (p_stat_clear)
		else $error("status bit not cleared");
	property p_irq_level;
		@(posedge i_clk) disable iff (!rst_n)
		(st.stat[1] && st.mask[1]) |-> o_irq;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("summary interrupt low while pending");
	property p_rst_regs;
		@(posedge i_clk) $rose(rst_n) |->
			(st.stat == DTM_IRQ_RESET) && (st.mask == DTM_IRQ_RESET);
	endproperty
	a_rst_regs: assert property (p_rst_regs)
		else $error("status or mask not clear after reset");
	c_b_irq: cover property (@(posedge i_clk) disable iff (!rst_n) $rose(o_b_irq));
	c_irq: cover property (@(posedge i_clk) disable iff (!rst_n) $rose(o_irq));
endmodule : dtm_top

// File: tb/test_dtm_top.sv
// bench: register-level tests of the dual reload timer
`timescale 1ns/1ns
module test_dtm_top;
	import dtm_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic o_a_irq;
	logic o_b_irq;
	logic o_irq;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [7:0] v;
	logic [7:0] w;

	dtm_top DUT (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.o_a_irq(o_a_irq),
		.o_b_irq(o_b_irq),
		.o_irq(o_irq)
	);

	always #25 i_clk = ~i_clk;

	task automatic finish_test();
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	// hang guard, well beyond the roughly 130 cycles the tests need
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			miscompares++;
			finish_test();
		end
	end

	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		n_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [7:0] e,
		input string n);
		logic [7:0] d;
		rd(a, d);
		chk(n, d, e);
	endtask : rc

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
	endtask : idle

	initial
	begin
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		idle(4);
		rc(DTM_OFS_CTRL, DTM_CTRL_RESET, "ctrl_reset");
		for (int i = 0; i < 4; i++)
			rc(DTM_OFS_B_LOW + 8'(i), 8'h00, "count_reset");
		rc(8'h00, 8'h00, "unmapped");
		wr(DTM_OFS_A_HIGH, 8'hFF);
		wr(DTM_OFS_A_LOW, 8'hF0);
		rc(DTM_OFS_A_HIGH, 8'hFF, "a_high");
		rc(DTM_OFS_A_LOW, 8'hF0, "a_low");
		wr(DTM_OFS_B_LOW, 8'hF0);
		wr(DTM_OFS_B_HIGH, 8'hFF);
		rc(DTM_OFS_B_HIGH, 8'hFF, "b_high");
		wr(DTM_OFS_CTRL, 8'h04);
		wr(DTM_OFS_A_LOW, 8'h34);
		wr(DTM_OFS_A_HIGH, 8'h12);
		rc(DTM_OFS_A_LOW, 8'hF0, "a_live");
		// timer three reloads, timer four runs free, both from FFF0
		wr(DTM_OFS_CTRL, 8'h36);
		idle(30);
		rc(DTM_OFS_CTRL, 8'hBE, "ctrl_flags");
		rc(DTM_OFS_A_HIGH, 8'h12, "a_reloaded");
		rc(DTM_OFS_B_HIGH, 8'h00, "b_wrapped");
		rd(DTM_OFS_B_LOW, v);
		rd(DTM_OFS_B_LOW, w);
		chk("b_step", w - v, 8'h02);
		chk("a_irq_off", o_a_irq, 8'h00);
		chk("b_irq_on", o_b_irq, 8'h01);
		rc(DTM_OFS_IRQ_STAT, 8'h03, "irq_stat");
		chk("irq_masked", o_irq, 8'h00);
		wr(DTM_OFS_IRQ_MASK, 8'h02);
		idle(2);
		chk("irq_on", o_irq, 8'h01);
		// enable both requests, halt timer three
		wr(DTM_OFS_CTRL, 8'hB9);
		idle(2);
		chk("a_irq", o_a_irq, 8'h01);
		chk("b_irq", o_b_irq, 8'h01);
		rd(DTM_OFS_A_LOW, v);
		idle(5);
		rc(DTM_OFS_A_LOW, v, "a_halted");
		wr(DTM_OFS_IRQ_STAT, 8'h03);
		idle(2);
		chk("irq_cleared", o_irq, 8'h00);
		wr(DTM_OFS_CTRL, 8'h31);
		idle(2);
		chk("a_irq_clr", o_a_irq, 8'h00);
		chk("b_irq_clr", o_b_irq, 8'h00);
		rc(DTM_OFS_CTRL, 8'h31, "ctrl_after");
		// timer four halted in reload mode: byte write goes to reload
		wr(DTM_OFS_CTRL, 8'h40);
		rd(DTM_OFS_B_LOW, v);
		wr(DTM_OFS_B_LOW, ~v);
		rc(DTM_OFS_B_LOW, v, "b_live");
		// second reset with both timers halted
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		idle(2);
		i_rst_n <= 1'b1;
		idle(4);
		rc(DTM_OFS_CTRL, DTM_CTRL_RESET, "ctrl_rst2");
		rc(DTM_OFS_B_LOW, 8'h00, "count_rst2");
		finish_test();
	end
endmodule : test_dtm_top
